/* File: rtl/dots_top.sv */
// Offset tracking scheduler with AHB-Lite register slave
`timescale 1ns/1ns
module dots_top (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             i_track,
	output logic             i_hold,
	output logic             q_track,
	output logic             q_hold,
	output logic             fast_settle
);
	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave
	logic [31:0] ctrl_reg;
	logic [31:0] tim_reg;
	logic        wpend_reg;
	logic        rpend_reg;
	logic [7:0]  addr_reg;
	logic        hready_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] status_w;
	logic [31:0] rd_mux_w;
	wire         accept_w;

	// Word transfers only; hsize is not checked since the master issues words
	assign accept_w = hsel && htrans[1] && hready;
	assign rd_mux_w = (addr_reg == dots_pkg::ADDR_CTRL)   ? ctrl_reg :
	                  (addr_reg == dots_pkg::ADDR_TIMING) ? tim_reg  :
	                  (addr_reg == dots_pkg::ADDR_STATUS) ? status_w : 32'h0000_0000;

	// Address phase capture; reads take one wait state so a prior write is visible
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wpend_reg  <= 1'b0;
			rpend_reg  <= 1'b0;
			addr_reg   <= 8'h00;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			wpend_reg  <= accept_w && hwrite;
			rpend_reg  <= accept_w && !hwrite;
			hready_reg <= !(accept_w && !hwrite);
			if (accept_w)
				addr_reg <= haddr[7:0];
			if (rpend_reg)
				hrdata_reg <= rd_mux_w;
		end
	end

	// Register writes in the data phase; unmapped writes are dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_reg <= dots_pkg::CTRL_RST;
			tim_reg  <= dots_pkg::TIM_RST;
		end else if (ce && wpend_reg) begin
			if (addr_reg == dots_pkg::ADDR_CTRL)
				ctrl_reg <= {20'h00000, 1'b0, hwdata[10:8], 3'h0, hwdata[4], 1'b0, hwdata[2:0]};
			if (addr_reg == dots_pkg::ADDR_TIMING)
				tim_reg  <= {10'h000, hwdata[21:16], 4'h0, hwdata[11:0]};
		end
	end

	assign hreadyout = hready_reg;
	assign hrdata    = hrdata_reg;
	assign hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Mode and ratio decode
	dots_pkg::dots_mode_t mode_w;
	dots_pkg::dots_mode_t mode_prev_reg;
	logic [2:0]  xsel_w;
	logic [6:0]  n_w;
	logic [1:0]  mult_w;
	logic [11:0] interval_w;
	logic [11:0] trk_len_w;
	wire         periodic_w;
	wire         oneshot_w;
	wire         cont_w;
	wire         mode_chg_w;

	assign mode_w     = dots_pkg::dots_mode_t'(ctrl_reg[dots_pkg::CTRL_MODE_LSB +: 3]);
	assign xsel_w     = ctrl_reg[dots_pkg::CTRL_XSEL_LSB +: 3];
	assign interval_w = tim_reg[dots_pkg::TIM_INT_LSB +: 12];
	assign trk_len_w  = {6'h00, tim_reg[dots_pkg::TIM_TRK_LSB +: 6]};
	// Codes 110 and 111 fall into none of these, so they hold like static
	assign periodic_w = (mode_w == dots_pkg::MODE_PER1) || (mode_w == dots_pkg::MODE_PER2) ||
	                    (mode_w == dots_pkg::MODE_PER3);
	assign oneshot_w  = (mode_w == dots_pkg::MODE_ONESHOT);
	assign cont_w     = (mode_w == dots_pkg::MODE_CONT);
	assign mode_chg_w = (mode_w != mode_prev_reg);
	// One-shot and continuous use a multiplier of one
	assign mult_w     = periodic_w ? mode_w[1:0] : 2'h1;
	// Invalid crystal codes fall back to the 48 ratio
	assign n_w        = (xsel_w == 3'h0) ? dots_pkg::N_SEL0 :
	                    (xsel_w == 3'h1) ? dots_pkg::N_SEL1 :
	                    (xsel_w == 3'h2) ? dots_pkg::N_SEL2 :
	                    (xsel_w == 3'h3) ? dots_pkg::N_SEL3 :
	                    (xsel_w == 3'h4) ? dots_pkg::N_SEL4 : dots_pkg::N_INVALID;

	////////////////////////////////////////////////////////////////////////
	// Reference tick prescaler
	dots_tick_if tk ();
	logic [8:0] period_w;

	assign period_w   = {7'h00, mult_w} * {2'h0, n_w};
	assign tk.period  = period_w[7:0];
	assign tk.restart = mode_chg_w;

	dots_tick_gen u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.tk      (tk)
	);

	////////////////////////////////////////////////////////////////////////
	// Cycle counter and window
	logic [11:0] cnt_reg;
	logic [11:0] cnt_next;
	logic        trk_reg;
	logic        hold_reg;
	logic        fast_reg;
	wire         in_win_w;
	wire         in_next_w;
	wire         cyc_end_w;
	wire         trk_next_w;

	// Window occupies the first track length ticks of each cycle; relies on interval above length
	assign in_win_w   = (cnt_reg < trk_len_w);
	assign cyc_end_w  = (cnt_reg >= interval_w - 12'h001);
	assign cnt_next   = mode_chg_w ? 12'h000 :
	                    !tk.tick   ? cnt_reg :
	                    periodic_w ? (cyc_end_w ? 12'h000 : cnt_reg + 12'h001) :
	                    (oneshot_w && in_win_w) ? cnt_reg + 12'h001 : cnt_reg;
	// Judged on the coming count so track lines up with it; a new mode then opens an exact window
	assign in_next_w  = (cnt_next < trk_len_w);
	// Static holds the last correction: only the hold strobe stays up
	assign trk_next_w = cont_w || ((periodic_w || oneshot_w) && in_next_w);

	// Counter, outputs and previous mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg       <= 12'h000;
			trk_reg       <= 1'b0;
			hold_reg      <= 1'b1;
			fast_reg      <= 1'b0;
			mode_prev_reg <= dots_pkg::MODE_STATIC;
		end else if (ce) begin
			cnt_reg       <= cnt_next;
			trk_reg       <= trk_next_w;
			hold_reg      <= !trk_next_w;
			fast_reg      <= ctrl_reg[dots_pkg::CTRL_FAST_BIT];
			mode_prev_reg <= mode_w;
		end
	end

	// One flop per control feeds both channels so they never skew
	assign i_track     = trk_reg;
	assign q_track     = trk_reg;
	assign i_hold      = hold_reg;
	assign q_hold      = hold_reg;
	assign fast_settle = fast_reg;

	assign status_w = {4'h0, cnt_reg, 14'h0000, oneshot_w && !in_win_w, trk_reg};

	////////////////////////////////////////////////////////////////////////
	// Checks
	iq_match_a: assert property (@(posedge clk) disable iff (sys_rst)
		(i_track == q_track) && (i_hold == q_hold) && (i_hold != i_track))
		else $error("I and Q controls differ");

	static_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && !periodic_w && !oneshot_w && !cont_w) |=> (!i_track && i_hold))
		else $error("tracking in static mode");

	cont_track_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && cont_w) |=> i_track)
		else $error("continuous mode not tracking");

	mode_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && mode_chg_w) |=> (cnt_reg == 12'h000))
		else $error("mode change did not restart count");

	ratio_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
		(xsel_w == 3'h2) |-> (tk.period == (8'(mult_w) * 8'h48)))
		else $error("wrong divider ratio");

	cycle_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && tk.tick && periodic_w && !mode_chg_w && cnt_reg == interval_w - 12'h001) |=> (cnt_reg == 12'h000))
		else $error("periodic cycle did not wrap");

	win_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && periodic_w && cnt_next == 12'h000 && trk_len_w != 12'h000) |=> i_track)
		else $error("no tracking at cycle start");

	win_end_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && (periodic_w || oneshot_w) && cnt_next >= trk_len_w) |=> !i_track)
		else $error("tracking past window length");

	fast_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
		ce |=> (fast_settle == $past(ctrl_reg[dots_pkg::CTRL_FAST_BIT])))
		else $error("fast settle not following control");
endmodule : dots_top

/* File: common/dots_pkg.sv */
// Package for the offset tracking scheduler: map, fields, resets, divider ratios, modes
package dots_pkg;
	// Register byte addresses
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_TIMING   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;
	// Control register fields
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_FAST_BIT = 4;
	localparam int          CTRL_XSEL_LSB = 8;
	// Timing register fields
	localparam int          TIM_INT_LSB   = 0;
	localparam int          TIM_TRK_LSB   = 16;
	// Status register fields
	localparam int          STAT_TRK_BIT  = 0;
	localparam int          STAT_DONE_BIT = 1;
	localparam int          STAT_CNT_LSB  = 16;
	// Reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0300;
	localparam logic [31:0] TIM_RST       = 32'h0001_0002;
	// Divider ratio per reference crystal select
	localparam logic [6:0]  N_SEL0        = 7'h30;
	localparam logic [6:0]  N_SEL1        = 7'h37;
	localparam logic [6:0]  N_SEL2        = 7'h48;
	localparam logic [6:0]  N_SEL3        = 7'h41;
	localparam logic [6:0]  N_SEL4        = 7'h30;
	localparam logic [6:0]  N_INVALID     = 7'h30;
	// Tracking modes
	typedef enum logic [2:0] {
		MODE_STATIC  = 3'b000,
		MODE_PER1    = 3'b001,
		MODE_PER2    = 3'b010,
		MODE_PER3    = 3'b011,
		MODE_ONESHOT = 3'b100,
		MODE_CONT    = 3'b101,
		MODE_RSV6    = 3'b110,
		MODE_RSV7    = 3'b111
	} dots_mode_t;
endpackage : dots_pkg

/* File: common/dots_tick_if.sv */
// Interface between the scheduler and its reference tick prescaler
`timescale 1ns/1ns
interface dots_tick_if;
	logic       restart;
	logic [7:0] period;
	logic       tick;
	modport gen (input restart, input period, output tick);
	modport user (output restart, output period, input tick);
endinterface : dots_tick_if

/* File: rtl/dots_tick_gen.sv */
// Prescaler: one tick every mode multiplier times N reference clocks
`timescale 1ns/1ns
module dots_tick_gen (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	dots_tick_if.gen tk
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	wire        last_w;

	// Wrap at period-1; restart forces phase zero so a new mode starts clean
	assign last_w   = (cnt_reg == tk.period - 8'h01);
	assign cnt_next = (tk.restart || last_w) ? 8'h00 : cnt_reg + 8'h01;
	assign tk.tick  = ce && last_w && !tk.restart;

	// Prescale counter
	always_ff @(posedge clk) begin
		if (sys_rst)
			cnt_reg <= 8'h00;
		else if (ce)
			cnt_reg <= cnt_next;
	end

	// Tick spacing equals the programmed period
	tick_space_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && tk.tick && !tk.restart) |=> (cnt_reg == 8'h00))
		else $error("prescaler did not wrap after tick");
endmodule : dots_tick_gen

/* File: dv/dots_analog_model.sv */
// Behavioural model of the I and Q offset correction and hold circuits
`timescale 1ns/1ns
module dots_analog_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        i_track,
	input  wire logic        i_hold,
	input  wire logic        q_track,
	input  wire logic        q_hold,
	output logic      [15:0] i_corr,
	output logic      [15:0] q_corr
);
	////////////////////////////////////////////////////////////////
	// Correction follows a drifting offset while tracking, else frozen
	// Conflicting track and hold scrambles the value, as a real loop would
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i_corr <= 16'h0000;
			q_corr <= 16'h0000;
		end else begin
			if (i_track == i_hold) i_corr <= ~i_corr;
			else if (i_track) i_corr <= i_corr + 16'h0001;
			if (q_track == q_hold) q_corr <= ~q_corr;
			else if (q_track) q_corr <= q_corr + 16'h0001;
		end
	end
endmodule : dots_analog_model

/* File: dv/tb_dc_offset_tracking_scheduler.sv */
// Testbench for the offset tracking scheduler
`timescale 1ns/1ns
module tb_dc_offset_tracking_scheduler;
	logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0]  htrans = 0;
	logic        hreadyout, hresp, i_track, i_hold, q_track, q_hold, fast_settle;
	logic [31:0] hrdata;
	logic [15:0] i_corr, q_corr, sv;
	int          error_cnt = 0, total_checks = 0, cyc = 0, x, lo, hi;
	int          md[5] = '{1, 2, 3, 1, 2};
	int          nn[5] = '{48, 55, 72, 65, 48};
	dots_top dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .i_track(i_track), .i_hold(i_hold), .q_track(q_track),
		.q_hold(q_hold), .fast_settle(fast_settle));
	dots_analog_model model_u (.clk(clk), .sys_rst(sys_rst), .i_track(i_track), .i_hold(i_hold),
		.q_track(q_track), .q_hold(q_hold), .i_corr(i_corr), .q_corr(q_corr));
	////////////////////////////////////////////////////////////////
	// Clock and hang guard; the longest run is well below the ceiling
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	// Compare, bus and measurement tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Each phase held until hready is seen high at a rising edge; read data taken at that edge
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask : rdchk
	task setc(input logic [2:0] xs, input logic f, input logic [2:0] m);
		xfer(1'b1, dots_pkg::ADDR_CTRL, {21'h000000, xs, 3'h0, f, 1'b0, m});
	endtask : setc
	task sett(input logic [5:0] len, input logic [11:0] iv);
		xfer(1'b1, dots_pkg::ADDR_TIMING, {10'h000, len, 4'h0, iv});
	endtask : sett
	// Counts falling-edge samples at one track level, capped at 3000
	task run(input logic lvl, output int n);
		n = 0;
		while (i_track === lvl && n < 3000) begin
			chk({29'h0, q_track, i_hold, q_hold}, {29'h0, i_track, ~i_track, ~i_track});
			n++;
			@(negedge clk);
		end
	endtask : run
	task final_report;
		$display("Mismatches %0d of %0d comparisons", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rdchk(dots_pkg::ADDR_CTRL, dots_pkg::CTRL_RST);
		rdchk(dots_pkg::ADDR_TIMING, dots_pkg::TIM_RST);
		xfer(1'b1, 8'h0c, 32'hffffffff);
		rdchk(8'h0c, 32'h00000000);
		chk({30'h0, i_track, i_hold}, 32'h00000001);
		setc(3'b010, 1'b1, 3'b000);
		rdchk(dots_pkg::ADDR_CTRL, 32'h00000210);
		chk({31'h0, fast_settle}, 32'h00000001);
		sett(6'd1, 12'd3);
		// Periodic modes over every crystal select: one high, two low units
		for (int k = 0; k < 5; k++) begin
			setc(3'(k), 1'b0, 3'(md[k]));
			@(negedge clk);
			run(1'b0, x);
			run(1'b1, x);
			run(1'b0, lo);
			run(1'b1, hi);
			chk(32'(lo), 32'(md[k] * nn[k] * 2));
			chk(32'(hi), 32'(md[k] * nn[k]));
			@(posedge clk);
		end
		chk({31'h0, fast_settle}, 32'h00000000);
		// One window then hold, then continuous tracking; static first so no window is open
		setc(3'b000, 1'b0, 3'b000);
		sett(6'd2, 12'd5);
		setc(3'b000, 1'b0, 3'b100);
		@(negedge clk);
		run(1'b0, x);
		run(1'b1, hi);
		run(1'b0, lo);
		chk(32'(hi), 32'd96);
		chk(32'(lo), 32'd3000);
		@(posedge clk);
		rdchk(dots_pkg::ADDR_STATUS, 32'h00020002);
		setc(3'b000, 1'b0, 3'b101);
		@(negedge clk);
		run(1'b0, x);
		run(1'b1, hi);
		chk(32'(hi), 32'd3000);
		// Static and reserved codes stop tracking and keep the correction
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			setc(3'b000, 1'b0, 3'b101);
			setc(3'b000, 1'b0, (k == 0) ? 3'b000 : 3'(5 + k));
			@(negedge clk);
			run(1'b1, x);
			sv = i_corr;
			run(1'b0, lo);
			chk(32'(lo), 32'd3000);
			chk({i_corr, q_corr}, {sv, sv});
		end
		final_report();
	end
endmodule : tb_dc_offset_tracking_scheduler
